// file: src/gic_init_config.sv
`timescale 1ns/1ps
// How it works
// - Start-up takes four samples ten milliseconds apart.
// - Start-up seeds charge level from first sample.
// - Four samples kept until next reset.
// - Code 0x04 data AA55..AA58 picks sample.
// - Code 0x07 AA55 measures now and seeds when converter idle; dropped during a conversion.
// - Immediate seeding finishes within 1.5 ms.
// - Cell temperature held within 0x0980..0x0DCC.
// - Auto temperature mode loads measured thermistor value.
// - Thermistor powered only during its measurement.
// - Code 0x09 reports supply voltage in millivolts.
// - Auto direction reports level freely both ways.
// - Charge never falls; discharge never rises, except on a seed pulse.
// - Pack-fit: high byte charge, low discharge.
// - Code 0x05 reports minutes to full.
// - Code 0x06 beta constant feeds thermistor conversion.
module gic_init_config #(
  parameter int SAMPLE_GAP = gic_pkg::SAMPLE_GAP_CYC,
  parameter int INIT_LIMIT = gic_pkg::INIT_LIMIT_CYC,
  parameter int VOLT_PERIOD = gic_pkg::VOLT_PERIOD_CYC,
  parameter int TEMP_PERIOD = gic_pkg::TEMP_PERIOD_CYC
) (
  // Clock, reset and clock enable.
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  // Word register port, addressed by command code.
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regCmd,
  input wire logic [15:0] regWrData,
  output logic [15:0] regRdData,
  output logic regRdValid,
  // Cell voltage converter.
  output logic adcStart,
  input wire logic adcDone,
  input wire logic [15:0] adcMv,
  // Cell thermistor pin power and its converter.
  output logic thermPowerOn,
  output logic thermConvStart,
  input wire logic thermDone,
  input wire logic [15:0] thermTemp,
  output logic [15:0] thermBeta,
  // Links to the rest of the gauge.
  input wire logic tempAutoEn,
  input wire logic [15:0] calcLevel,
  input wire logic [15:0] calcTimeToFull,
  output logic seedStrobe,
  output logic [15:0] seedMv,
  output logic [15:0] reportedLevel,
  output logic [15:0] cellTemp,
  output logic [7:0] packFitCharge,
  output logic [7:0] packFitDischarge,
  output logic startupDone
);
  import gic_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks.
  // ----------------------------------------------------------------
  if (SAMPLE_GAP < 2 || SAMPLE_GAP >= (1 << CNT_W) ||
      INIT_LIMIT < 2 || INIT_LIMIT >= (1 << CNT_W) ||
      VOLT_PERIOD < 1 || VOLT_PERIOD >= (1 << CNT_W) ||
      TEMP_PERIOD <= THERM_SETTLE_CYC ||
      TEMP_PERIOD >= (1 << CNT_W)) begin : g_bad_count
    $error("Timing parameter outside counter range.");
  end

  // Clamps a temperature word into the legal range.
  function automatic logic [15:0] clampTemp(input logic [15:0] t);
    if (t < TEMP_MIN) begin
      return TEMP_MIN;
    end else if (t > TEMP_MAX) begin
      return TEMP_MAX;
    end
    return t;
  endfunction

  // ----------------------------------------------------------------
  // Register port decode.
  // ----------------------------------------------------------------
  logic wrSelect; // Valid sample-select write.
  logic wrImmediate; // Valid immediate-init write.
  logic [1:0] selIdx; // Sample chosen by the select key.
  assign wrSelect = regWrEn && regCmd == CMD_SAMPLE_SELECT &&
                    regWrData >= KEY_FIRST && regWrData <= KEY_LAST;
  assign selIdx = 2'(regWrData - KEY_FIRST);
  assign wrImmediate = regWrEn && regCmd == CMD_IMMEDIATE &&
                       regWrData == KEY_FIRST;

  // Stored registers.
  logic [15:0] sample_r [NUM_SAMPLES]; // Start-up voltage samples.
  logic [15:0] cellMv_r; // Latest measured supply voltage.
  logic [15:0] beta_r; // Thermistor beta constant.
  logic [15:0] temp_r; // Cell temperature.
  logic [15:0] dir_r; // Reporting direction mode.
  logic [15:0] fit_r; // Pack-fit parameter.
  logic [15:0] ttf_r; // Minutes to full.

  // ----------------------------------------------------------------
  // Voltage sequencer.
  // ----------------------------------------------------------------
  gic_vstate_type vState_r; // Converter handshake state.
  logic [CNT_W-1:0] vCnt_r; // Gap or period counter.
  logic [2:0] sampleCnt_r; // Start-up samples taken.
  logic immPending_r; // Immediate seeding in progress.
  logic [CNT_W-1:0] immCnt_r; // Cycles since immediate command.
  logic immTimeout; // Deadline reached before conversion.
  logic busy;
  assign busy = vState_r != V_IDLE;
  assign immTimeout = immPending_r &&
                      immCnt_r == CNT_W'(INIT_LIMIT - 2);

  // Steps the converter: gap timing, requests and results.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      vState_r <= V_IDLE;
      vCnt_r <= '0;
      sampleCnt_r <= '0;
      adcStart <= 1'b0;
    end else if (ce) begin
      adcStart <= 1'b0;
      unique case (vState_r)
        V_IDLE: begin
          // First sample goes at once; later ones wait out the gap.
          if (wrImmediate) begin
            vState_r <= V_REQ;
          end else if (sampleCnt_r < 3'(NUM_SAMPLES)) begin
            if (sampleCnt_r == 3'd0 ||
                vCnt_r >= CNT_W'(SAMPLE_GAP - 2)) begin
              // The request state adds one cycle, so stop one short.
              vState_r <= V_REQ;
            end else begin
              vCnt_r <= vCnt_r + 1'b1;
            end
          end else if (vCnt_r >= CNT_W'(VOLT_PERIOD - 1)) begin
            vState_r <= V_REQ;
          end else begin
            vCnt_r <= vCnt_r + 1'b1;
          end
        end
        V_REQ: begin
          adcStart <= 1'b1;
          vCnt_r <= '0;
          vState_r <= V_BUSY;
        end
        V_BUSY: begin
          // The gap counts from one request to the next.
          vCnt_r <= vCnt_r + 1'b1;
          if (adcDone) begin
            vState_r <= V_IDLE;
            if (sampleCnt_r < 3'(NUM_SAMPLES)) begin
              sampleCnt_r <= sampleCnt_r + 1'b1;
            end
          end
        end
      endcase
    end
  end

  // Captures start-up samples; they never change until reset.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_SAMPLES; i++) begin
        sample_r[i] <= RST_WORD;
      end
    end else if (ce) begin
      if (vState_r == V_BUSY && adcDone &&
          sampleCnt_r < 3'(NUM_SAMPLES) && !immPending_r) begin
        sample_r[sampleCnt_r[1:0]] <= adcMv;
      end
    end
  end

  // Keeps the latest supply voltage in millivolts.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cellMv_r <= RST_WORD;
    end else if (ce && vState_r == V_BUSY && adcDone) begin
      cellMv_r <= adcMv;
    end
  end

  // Tracks the immediate-init deadline.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      immPending_r <= 1'b0;
      immCnt_r <= '0;
    end else if (ce) begin
      if (wrImmediate && !busy && !immPending_r) begin
        immPending_r <= 1'b1;
        immCnt_r <= '0;
      end else if (immPending_r) begin
        immCnt_r <= immCnt_r + 1'b1;
        if ((vState_r == V_BUSY && adcDone) || immTimeout) begin
          immPending_r <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Seeding of the charge level.
  // ----------------------------------------------------------------
  // Issues one seed pulse with the voltage to start from.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      seedStrobe <= 1'b0;
      seedMv <= RST_WORD;
      startupDone <= 1'b0;
    end else if (ce) begin
      seedStrobe <= 1'b0;
      if (!startupDone && sampleCnt_r == 3'(NUM_SAMPLES)) begin
        // End of start-up: seed from the first sample.
        startupDone <= 1'b1;
        seedStrobe <= 1'b1;
        seedMv <= sample_r[0];
      end else if (immPending_r && vState_r == V_BUSY && adcDone) begin
        seedStrobe <= 1'b1;
        seedMv <= adcMv;
      end else if (immTimeout) begin
        // Converter too slow: fall back to the last voltage known.
        seedStrobe <= 1'b1;
        seedMv <= cellMv_r;
      end else if (wrSelect && startupDone) begin
        seedStrobe <= 1'b1;
        seedMv <= sample_r[selIdx];
      end
    end
  end

  // Reports the level under the chosen direction mode.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reportedLevel <= RST_WORD;
    end else if (ce) begin
      if (seedStrobe || dir_r == DIR_AUTO) begin
        reportedLevel <= calcLevel;
      end else if (dir_r == DIR_CHARGE) begin
        if (calcLevel > reportedLevel) begin
          reportedLevel <= calcLevel;
        end
      end else if (dir_r == DIR_DISCHARGE) begin
        if (calcLevel < reportedLevel) begin
          reportedLevel <= calcLevel;
        end
      end else begin
        reportedLevel <= calcLevel;
      end
    end
  end

  // ----------------------------------------------------------------
  // Thermistor measurement.
  // ----------------------------------------------------------------
  gic_tstate_type tState_r; // Thermistor sequencer state.
  logic [CNT_W-1:0] tCnt_r; // Period and settle counter.

  // Powers the pin, waits to settle, converts, then powers down.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tState_r <= T_IDLE;
      tCnt_r <= '0;
      thermPowerOn <= 1'b0;
      thermConvStart <= 1'b0;
    end else if (ce) begin
      thermConvStart <= 1'b0;
      unique case (tState_r)
        T_IDLE: begin
          thermPowerOn <= 1'b0;
          if (!tempAutoEn) begin
            tCnt_r <= '0;
          end else if (tCnt_r >= CNT_W'(TEMP_PERIOD - 1)) begin
            tCnt_r <= '0;
            thermPowerOn <= 1'b1;
            tState_r <= T_SETTLE;
          end else begin
            tCnt_r <= tCnt_r + 1'b1;
          end
        end
        T_SETTLE: begin
          tCnt_r <= tCnt_r + 1'b1;
          if (tCnt_r >= CNT_W'(THERM_SETTLE_CYC - 1)) begin
            tCnt_r <= '0;
            thermConvStart <= 1'b1;
            tState_r <= T_CONV;
          end
        end
        T_CONV: begin
          if (thermDone) begin
            thermPowerOn <= 1'b0;
            tState_r <= T_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Host-visible registers.
  // ----------------------------------------------------------------
  // Cell temperature: measured in auto mode, host-written otherwise.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      temp_r <= RST_TEMP;
    end else if (ce) begin
      if (tempAutoEn && tState_r == T_CONV && thermDone) begin
        temp_r <= clampTemp(thermTemp);
      end else if (!tempAutoEn && regWrEn && regCmd == CMD_CELL_TEMP) begin
        temp_r <= clampTemp(regWrData);
      end
    end
  end

  // Plain read-write configuration words.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      beta_r <= RST_BETA;
      dir_r <= DIR_AUTO;
      fit_r <= RST_PACK_FIT;
    end else if (ce && regWrEn) begin
      if (regCmd == CMD_THERM_BETA) begin
        beta_r <= regWrData;
      end
      if (regCmd == CMD_DIRECTION) begin
        dir_r <= regWrData;
      end
      if (regCmd == CMD_PACK_FIT) begin
        fit_r <= regWrData;
      end
    end
  end

  // Minutes to full from the gauge calculation.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ttf_r <= RST_WORD;
    end else if (ce) begin
      ttf_r <= calcTimeToFull;
    end
  end

  // Drives the configuration outputs from their registers.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      thermBeta <= RST_BETA;
      cellTemp <= RST_TEMP;
      packFitCharge <= RST_PACK_FIT[FIT_CHG_LSB +: 8];
      packFitDischarge <= RST_PACK_FIT[FIT_DIS_LSB +: 8];
    end else if (ce) begin
      thermBeta <= beta_r;
      cellTemp <= temp_r;
      packFitCharge <= fit_r[FIT_CHG_LSB +: 8];
      packFitDischarge <= fit_r[FIT_DIS_LSB +: 8];
    end
  end

  // Read answer, one cycle after the request; others read zero.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      regRdData <= RST_WORD;
      regRdValid <= 1'b0;
    end else if (ce) begin
      regRdValid <= regRdEn;
      if (regRdEn) begin
        unique case (regCmd)
          CMD_TIME_TO_FULL: regRdData <= ttf_r;
          CMD_THERM_BETA: regRdData <= beta_r;
          CMD_CELL_TEMP: regRdData <= temp_r;
          CMD_CELL_VOLT: regRdData <= cellMv_r;
          CMD_DIRECTION: regRdData <= dir_r;
          CMD_PACK_FIT: regRdData <= fit_r;
          default: regRdData <= RST_WORD;
        endcase
      end
    end
  end
endmodule

// file: src/gic_pkg.sv
package gic_pkg;
  // ----------------------------------------------------------------
  // Clock and timing.
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int SAMPLE_GAP_US = 10000;
  localparam int SAMPLE_GAP_CYC = SAMPLE_GAP_US * (CLK_HZ / 1000000);
  localparam int INIT_LIMIT_US = 1500;
  localparam int INIT_LIMIT_CYC = INIT_LIMIT_US * (CLK_HZ / 1000000);
  localparam int VOLT_PERIOD_MS = 1000;
  localparam int VOLT_PERIOD_CYC = VOLT_PERIOD_MS * (CLK_HZ / 1000);
  localparam int TEMP_PERIOD_MS = 1000;
  localparam int TEMP_PERIOD_CYC = TEMP_PERIOD_MS * (CLK_HZ / 1000);
  localparam int THERM_SETTLE_US = 8;
  localparam int THERM_SETTLE_CYC = THERM_SETTLE_US * (CLK_HZ / 1000000);
  localparam int NUM_SAMPLES = 4;
  localparam int CNT_W = 26;
  // ----------------------------------------------------------------
  // Command codes.
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_SAMPLE_SELECT = 8'h04;
  localparam logic [7:0] CMD_TIME_TO_FULL = 8'h05;
  localparam logic [7:0] CMD_THERM_BETA = 8'h06;
  localparam logic [7:0] CMD_IMMEDIATE = 8'h07;
  localparam logic [7:0] CMD_CELL_TEMP = 8'h08;
  localparam logic [7:0] CMD_CELL_VOLT = 8'h09;
  localparam logic [7:0] CMD_DIRECTION = 8'h0a;
  localparam logic [7:0] CMD_PACK_FIT = 8'h0b;
  // ----------------------------------------------------------------
  // Data values and field layout.
  // ----------------------------------------------------------------
  localparam logic [15:0] KEY_FIRST = 16'haa55;
  localparam logic [15:0] KEY_LAST = 16'haa58;
  localparam logic [15:0] TEMP_MIN = 16'h0980;
  localparam logic [15:0] TEMP_MAX = 16'h0dcc;
  localparam logic [15:0] DIR_AUTO = 16'h0000;
  localparam logic [15:0] DIR_CHARGE = 16'h0001;
  localparam logic [15:0] DIR_DISCHARGE = 16'hffff;
  localparam int FIT_CHG_LSB = 8;
  localparam int FIT_DIS_LSB = 0;
  // ----------------------------------------------------------------
  // Reset values.
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_BETA = 16'h0d34;
  localparam logic [15:0] RST_TEMP = 16'h0ba6;
  localparam logic [15:0] RST_PACK_FIT = 16'h0000;
  localparam logic [15:0] RST_WORD = 16'h0000;
  // Converter sequencer states, one bit changing per step except the return to idle.
  typedef enum logic [1:0] {
    V_IDLE = 2'b00,
    V_REQ = 2'b01,
    V_BUSY = 2'b11
  } gic_vstate_type;
  typedef enum logic [1:0] {
    T_IDLE = 2'b00,
    T_SETTLE = 2'b01,
    T_CONV = 2'b11
  } gic_tstate_type;
endpackage

// file: test/gic_conv_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Converter stand-in; data lines churn between answers.
// ----------------------------------------------------------------
module gic_conv_model (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Bench controls.
  input wire logic [15:0] mvBase,
  input wire logic [3:0] adcLat,
  input wire logic adcMute,
  input wire logic [15:0] tempVal,
  // Converter handshakes.
  input wire logic adcStart,
  output logic adcDone,
  output logic [15:0] adcMv,
  input wire logic thermPowerOn,
  input wire logic thermConvStart,
  output logic thermDone,
  output logic [15:0] thermTemp
);
  logic [3:0] adcCnt_r; // Cycles left in a conversion.
  logic adcBusy_r; // A voltage conversion runs.
  logic [15:0] nDone_r; // Results given so far.
  logic tBusy_r; // A thermistor conversion runs.
  // Voltage results ramp by 7 mV a result from mvBase.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      adcBusy_r <= 1'b0;
      adcCnt_r <= 4'h0;
      adcDone <= 1'b0;
      adcMv <= 16'h5a5a;
      nDone_r <= 16'h0000;
    end else if (adcBusy_r && adcCnt_r == 4'h0) begin
      adcBusy_r <= 1'b0;
      adcDone <= 1'b1;
      adcMv <= mvBase + 16'h0007 * nDone_r;
      nDone_r <= nDone_r + 16'h0001;
    end else begin
      adcDone <= 1'b0;
      adcMv <= ~adcMv;
      adcCnt_r <= adcCnt_r - 4'h1;
      if (adcStart && !adcMute) begin
        adcBusy_r <= 1'b1;
        adcCnt_r <= adcLat;
      end
    end
  end
  // A reading comes only while the thermistor pin is powered.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tBusy_r <= 1'b0;
      thermDone <= 1'b0;
      thermTemp <= 16'ha5a5;
    end else if (tBusy_r && thermPowerOn) begin
      tBusy_r <= 1'b0;
      thermDone <= 1'b1;
      thermTemp <= tempVal;
    end else begin
      tBusy_r <= thermConvStart;
      thermDone <= 1'b0;
      thermTemp <= ~thermTemp;
    end
  end
endmodule

// file: test/gic_init_config_checker.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port checker for the init and configuration registers.
// ----------------------------------------------------------------
module gic_init_config_checker (
  // Clock, reset and clock enable.
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  // Register port.
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regCmd,
  input wire logic [15:0] regWrData,
  input wire logic [15:0] regRdData,
  input wire logic regRdValid,
  // Thermistor, seeding and copies.
  input wire logic thermPowerOn,
  input wire logic thermConvStart,
  input wire logic thermDone,
  input wire logic [15:0] thermTemp,
  input wire logic [15:0] thermBeta,
  input wire logic startupDone,
  input wire logic seedStrobe,
  input wire logic [15:0] cellTemp,
  input wire logic [7:0] packFitCharge,
  input wire logic [7:0] packFitDischarge
);
  import gic_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic wr; // A write taken at this edge.
  assign wr = regWrEn && ce;
  AST_RD_VALID: assert property (regRdEn && ce |=> regRdValid)
    else $error("read not answered");
  AST_WO_READ: assert property (regRdEn && ce &&
    (regCmd == CMD_SAMPLE_SELECT || regCmd == CMD_IMMEDIATE)
    |=> regRdData == 16'h0000) else $error("command code read not zero");
  AST_TEMP_RANGE: assert property (cellTemp >= TEMP_MIN &&
    cellTemp <= TEMP_MAX) else $error("cell temperature out of range");
  AST_FIT_SPLIT: assert property (wr && regCmd == CMD_PACK_FIT
    |-> ##2 {packFitCharge, packFitDischarge} == $past(regWrData, 2))
    else $error("pack fit halves wrong");
  AST_BETA: assert property (wr && regCmd == CMD_THERM_BETA
    |-> ##2 thermBeta == $past(regWrData, 2))
    else $error("beta copy wrong");
  AST_SEL_SEED: assert property (wr && startupDone &&
    regCmd == CMD_SAMPLE_SELECT && regWrData >= KEY_FIRST &&
    regWrData <= KEY_LAST |=> seedStrobe) else $error("no reseed");
  AST_PWR_CONV: assert property (thermConvStart |-> thermPowerOn)
    else $error("conversion without power");
  AST_PWR_OFF: assert property (thermDone && thermPowerOn && ce
    |=> !thermPowerOn) else $error("power held after reading");
  AST_AUTO_TEMP: assert property (thermDone && thermPowerOn && ce &&
    thermTemp >= TEMP_MIN && thermTemp <= TEMP_MAX
    |-> ##2 cellTemp == $past(thermTemp, 2))
    else $error("reading not loaded");
endmodule
bind gic_init_config gic_init_config_checker u_chk (.ref_clk, .rst, .ce,
  .regWrEn, .regRdEn, .regCmd, .regWrData, .regRdData, .regRdValid,
  .thermPowerOn, .thermConvStart, .thermDone, .thermTemp, .thermBeta,
  .startupDone, .seedStrobe, .cellTemp, .packFitCharge, .packFitDischarge);

// file: test/gic_init_config_test.sv
`timescale 1ns/1ps
module gic_init_config_test;
  import gic_pkg::*;
  // ----------------------------------------------------------------
  // Signals, shortened counts and bench state.
  // ----------------------------------------------------------------
  localparam int GAP = 20;
  localparam int LIMIT = 50;
  logic ref_clk, rst, ce, regWrEn, regRdEn, regRdValid, adcStart, adcDone;
  logic thermPowerOn, thermConvStart, thermDone, tempAutoEn, adcMute;
  logic seedStrobe, startupDone;
  logic [7:0] regCmd, packFitCharge, packFitDischarge;
  logic [3:0] adcLat;
  logic [15:0] regWrData, regRdData, adcMv, thermTemp, thermBeta, tempVal;
  logic [15:0] calcLevel, calcTimeToFull, seedMv, reportedLevel, cellTemp;
  logic [15:0] mvBase, lastMv, firstSeed, v, e;
  logic [15:0] modes [4] = '{DIR_AUTO, DIR_CHARGE, DIR_DISCHARGE, DIR_AUTO};
  int cyc, failures, n_checks, nRes, nSeed;
  int startT[$];
  bit f;
  gic_init_config #(.SAMPLE_GAP(GAP), .INIT_LIMIT(LIMIT), .VOLT_PERIOD(100),
    .TEMP_PERIOD(300)) DUT (.ref_clk, .rst, .ce, .regWrEn, .regRdEn,
    .regCmd, .regWrData, .regRdData, .regRdValid, .adcStart, .adcDone,
    .adcMv, .thermPowerOn, .thermConvStart, .thermDone, .thermTemp,
    .thermBeta, .tempAutoEn, .calcLevel, .calcTimeToFull, .seedStrobe,
    .seedMv, .reportedLevel, .cellTemp, .packFitCharge, .packFitDischarge,
    .startupDone);
  gic_conv_model u_model (.ref_clk, .rst, .mvBase, .adcLat, .adcMute,
    .tempVal, .adcStart, .adcDone, .adcMv, .thermPowerOn, .thermConvStart,
    .thermDone, .thermTemp);
  // ----------------------------------------------------------------
  // Clock, monitor, timeout and shared tasks.
  // ----------------------------------------------------------------
  always #20 ref_clk = ~ref_clk;
  // Counts cycles and cuts a hang short.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      stop_test();
    end
  end
  // Records converter starts, results and seeds where they are settled.
  always @(negedge ref_clk) begin
    if (adcStart) startT.push_back(cyc);
    if (adcDone) begin
      lastMv = adcMv;
      nRes++;
    end
    if (seedStrobe && nSeed++ == 0) firstSeed = seedMv;
  end
  // Ramp value of the k-th conversion result.
  function automatic logic [15:0] exp_mv(input int k);
    return mvBase + 16'(7 * k);
  endfunction
  // Reported level after direction filtering.
  function automatic logic [15:0] next_lvl(input logic [15:0] m, p, c);
    if (m == DIR_CHARGE && c < p) return p;
    if (m == DIR_DISCHARGE && c > p) return p;
    return c;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(posedge ref_clk);
    regWrEn <= 1'b1;
    regCmd <= c;
    regWrData <= d;
    @(posedge ref_clk);
    regWrEn <= 1'b0;
    #1;
  endtask
  // Reads one word and compares it.
  task automatic rdc(input logic [7:0] c, input logic [15:0] exp);
    @(posedge ref_clk);
    regRdEn <= 1'b1;
    regCmd <= c;
    @(posedge ref_clk);
    regRdEn <= 1'b0;
    #1;
    check(16'(regRdValid), 16'h0001);
    check(regRdData, exp);
  endtask
  task automatic wait_seed(input int n, output bit found);
    found = 0;
    for (int j = 0; j < n && !found; j++) begin
      @(posedge ref_clk);
      #1;
      found = (seedStrobe === 1'b1);
    end
  endtask
  // Returns at the edge after a fresh conversion result.
  task automatic wait_adc;
    int k0;
    k0 = nRes;
    for (int j = 0; j < 400 && nRes == k0; j++) @(posedge ref_clk);
  endtask
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial begin
    {ref_clk, ce, regWrEn, regRdEn, tempAutoEn, adcMute} = 6'b010000;
    {rst, regCmd, regWrData, calcLevel, calcTimeToFull} = '0;
    rst = 1'b1;
    tempVal = TEMP_MIN;
    v = 16'($urandom(59));
    mvBase = 16'(3000 + $urandom_range(1000));
    adcLat = 4'($urandom_range(8, 2));
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    wr(CMD_SAMPLE_SELECT, KEY_FIRST);
    check(16'(seedStrobe), 16'h0000);
    rdc(CMD_THERM_BETA, RST_BETA);
    rdc(CMD_CELL_TEMP, RST_TEMP);
    rdc(CMD_PACK_FIT, RST_PACK_FIT);
    for (int j = 0; j < 1000 && startupDone !== 1'b1; j++) @(posedge ref_clk);
    for (int i = 1; i < 4; i++) check(16'(startT[i] - startT[i-1]), 16'(GAP));
    check(firstSeed, exp_mv(0));
    $display("test start-up done");
    for (int k = 0; k < 4; k++) begin
      wr(CMD_SAMPLE_SELECT, KEY_FIRST + 16'(k));
      check(16'(seedStrobe), 16'h0001);
      check(seedMv, exp_mv(k));
    end
    foreach (modes[i]) begin
      wr(CMD_SAMPLE_SELECT, (i % 2) ? KEY_LAST + 16'h1 : KEY_FIRST - 16'h1);
      check(16'(seedStrobe), 16'h0000);
    end
    $display("test sample select done");
    calcTimeToFull <= 16'($urandom);
    wr(CMD_TIME_TO_FULL, 16'h1234);
    rdc(CMD_TIME_TO_FULL, calcTimeToFull);
    rdc(8'h0c, 16'h0000);
    rdc(CMD_IMMEDIATE, 16'h0000);
    wait_adc();
    rdc(CMD_CELL_VOLT, lastMv);
    wait_adc();
    e = exp_mv(nRes);
    wr(CMD_IMMEDIATE, KEY_FIRST);
    wait_seed(LIMIT, f);
    check(16'(f), 16'h0001);
    check(seedMv, e);
    wait_adc();
    wr(CMD_IMMEDIATE, KEY_FIRST + 16'h1);
    wait_seed(LIMIT, f);
    check(16'(f), 16'h0000);
    $display("test immediate seed done");
    v = TEMP_MIN + 16'($urandom_range(16'h044c));
    wr(CMD_CELL_TEMP, v);
    rdc(CMD_CELL_TEMP, v);
    wr(CMD_CELL_TEMP, 16'h0000);
    rdc(CMD_CELL_TEMP, TEMP_MIN);
    wr(CMD_CELL_TEMP, 16'hffff);
    @(posedge ref_clk);
    #1;
    check(cellTemp, TEMP_MAX);
    tempAutoEn <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      tempVal <= k ? 16'h0100 : TEMP_MIN + 16'($urandom_range(16'h044c));
      for (int j = 0; j < 600 && thermDone !== 1'b1; j++) begin
        @(posedge ref_clk);
        #1;
      end
      repeat (2) @(posedge ref_clk);
      #1;
      check(cellTemp, k ? TEMP_MIN : tempVal);
    end
    tempAutoEn <= 1'b0;
    $display("test temperature done");
    e = 16'h0000;
    foreach (modes[i]) begin
      wr(CMD_DIRECTION, modes[i]);
      rdc(CMD_DIRECTION, modes[i]);
      repeat (4) begin
        @(posedge ref_clk);
        v = 16'($urandom_range(100));
        calcLevel <= v;
        e = next_lvl(modes[i], e, v);
        repeat (2) @(posedge ref_clk);
        #1;
        check(reportedLevel, e);
      end
    end
    $display("test direction done");
    for (int k = 0; k < 4; k++) begin
      v = 16'($urandom);
      wr(k % 2 ? CMD_THERM_BETA : CMD_PACK_FIT, v);
      @(posedge ref_clk);
      #1;
      check(k % 2 ? thermBeta : {packFitCharge, packFitDischarge}, v);
      rdc(k % 2 ? CMD_THERM_BETA : CMD_PACK_FIT, v);
    end
    $display("test fit and beta done");
    wait_adc();
    adcMute <= 1'b1;
    wr(CMD_IMMEDIATE, KEY_FIRST);
    wait_seed(LIMIT, f);
    check(16'(f), 16'h0001);
    check(seedMv, lastMv);
    $display("test silent converter done");
    stop_test();
  end
endmodule
